// file: verilog/disc_ctrl.sv
// Disconnector command pulses, position decoding and operation counter.
// Assumes asynchronous feedback and permission pins, one 200 MHz clock,
// and a classic Wishbone master for the register file.

// Contract
// - Accepted open request drives the open pulse for the pulse duration.
// - Accepted close request drives the close pulse for the pulse duration.
// - Each disconnector operation raises the switching event pulse 150 ms.
// - Filtered closed indication comes from the position feedback.
// - Filtered opened indication comes from the position feedback.
// - Operation counter adds one whenever the switching pulse activates.
// - A host clear request zeroes the operation counter.
// - Position code: 0 intermediate, 1 off, 2 on, 3 bad.
// - Every change of the position code raises a state event.
// - Request value off maps to open pulse, on to close pulse.
// - Execute only with local/remote permission and direction permit.
// - Timings hold within 5 percent or 15 ms, whichever larger.
// - Pulse duration settable 100 to 60000 ms, default 1000 ms.
// - Intermediate reported only after feedback stays between longer.
// - Enhanced mode flags error if position stays after max time.
module disc_ctrl #(
   parameter int TICK_CYCLES = disc_ctrl_pkg::CYC_PER_TICK,
   parameter int TICK_W = 18
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic open_feedback_in,
   input wire logic closed_feedback_in,
   input wire logic open_permit_in,
   input wire logic close_permit_in,
   input wire logic local_enable_in,
   input wire logic remote_enable_in,
   input wire logic block_in,
   output logic open_pulse_out,
   output logic close_pulse_out,
   output logic switching_event_pulse,
   output logic filtered_closed_out,
   output logic filtered_opened_out,
   output logic [1:0] position_state_code,
   output logic state_event_pulse,
   output logic irq
);
   typedef struct packed {
      logic [6:0] sync1;
      logic [6:0] sync2;
      logic [TICK_W-1:0] tick_cnt;
      logic tick;
      logic ack;
      logic [31:0] dat;
      logic enh;
      logic [15:0] pulse_ms;
      logic [15:0] inter_ms;
      logic [15:0] maxop_ms;
      logic [disc_ctrl_pkg::IRQ_W-1:0] mask;
      logic [disc_ctrl_pkg::IRQ_W-1:0] stat;
      disc_ctrl_pkg::cmd_state_t st;
      logic [15:0] pulse_cnt;
      logic open_p;
      logic close_p;
      logic [15:0] inter_cnt;
      logic [1:0] code;
      logic closed_f;
      logic opened_f;
      logic [15:0] op_cnt;
      logic op_p;
      logic [15:0] op_count;
      logic evt;
      logic maxop_on;
      logic [15:0] maxop_cnt;
      logic [1:0] start_code;
      logic irq;
   } state_t;

   state_t s_r;
   state_t s_nxt;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] lanes(input logic [15:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] sel);
      lanes = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
   endfunction

   function automatic logic [15:0] clamp(input logic [15:0] v,
                                         input logic [15:0] lo);
      clamp = (v < lo) ? lo : (v > disc_ctrl_pkg::TIME_MAX_MS) ?
              disc_ctrl_pkg::TIME_MAX_MS : v;
   endfunction

   logic acc;
   logic wr;
   logic [1:0] raw_code;
   logic cmd_wr;
   logic req_on;
   logic src_ok;
   logic dir_ok;
   logic accept;
   logic cnt_clr;

   assign acc = wb_cyc_i & wb_stb_i & ~s_r.ack;
   assign wr = acc & wb_we_i;
   // Bit 1 closed feedback, bit 0 open feedback
   assign raw_code = {s_r.sync2[1], s_r.sync2[0]};
   assign cmd_wr = wr && wb_adr_i == disc_ctrl_pkg::A_CMD && wb_sel_i[0];
   assign req_on = wb_dat_i[disc_ctrl_pkg::CMD_ON_BIT];
   assign src_ok = wb_dat_i[disc_ctrl_pkg::CMD_LOCAL_BIT] ?
                   s_r.sync2[4] : s_r.sync2[5];
   assign dir_ok = req_on ? s_r.sync2[3] : s_r.sync2[2];
   assign accept = cmd_wr && src_ok && dir_ok && !s_r.sync2[6] &&
                   s_r.st == disc_ctrl_pkg::CMD_IDLE;
   assign cnt_clr = wr && wb_adr_i == disc_ctrl_pkg::A_COUNT;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [disc_ctrl_pkg::IRQ_W-1:0] ev;
      logic [disc_ctrl_pkg::IRQ_W-1:0] w1c;
      ev = '0;
      w1c = '0;
      s_nxt = s_r;
      s_nxt.sync1 = {block_in, remote_enable_in, local_enable_in,
                     close_permit_in, open_permit_in,
                     closed_feedback_in, open_feedback_in};
      s_nxt.sync2 = s_r.sync1;
      s_nxt.tick = s_r.tick_cnt == TICK_W'(TICK_CYCLES - 1);
      s_nxt.tick_cnt = s_nxt.tick ? '0 : s_r.tick_cnt + 1'b1;
      s_nxt.ack = acc;
      s_nxt.evt = 1'b0;

      // Register writes
      if (wr) begin
         case (wb_adr_i)
            disc_ctrl_pkg::A_CTRL: begin
               if (wb_sel_i[0])
                  s_nxt.enh = wb_dat_i[disc_ctrl_pkg::CTRL_ENH_BIT];
            end
            disc_ctrl_pkg::A_PULSE: begin
               s_nxt.pulse_ms = clamp(lanes(s_r.pulse_ms, wb_dat_i,
                  wb_sel_i), disc_ctrl_pkg::PULSE_MIN_MS);
            end
            disc_ctrl_pkg::A_INTER: begin
               s_nxt.inter_ms = clamp(lanes(s_r.inter_ms, wb_dat_i,
                  wb_sel_i), disc_ctrl_pkg::INTER_MIN_MS);
            end
            disc_ctrl_pkg::A_MAXOP: begin
               s_nxt.maxop_ms = clamp(lanes(s_r.maxop_ms, wb_dat_i,
                  wb_sel_i), disc_ctrl_pkg::MAXOP_MIN_MS);
            end
            disc_ctrl_pkg::A_IRQ_STAT: begin
               if (wb_sel_i[0])
                  w1c = wb_dat_i[disc_ctrl_pkg::IRQ_W-1:0];
            end
            disc_ctrl_pkg::A_IRQ_MASK: begin
               if (wb_sel_i[0])
                  s_nxt.mask = wb_dat_i[disc_ctrl_pkg::IRQ_W-1:0];
            end
            default: begin
            end
         endcase
      end

      // Read data
      case (wb_adr_i)
         disc_ctrl_pkg::A_CTRL: s_nxt.dat = {31'h0, s_r.enh};
         disc_ctrl_pkg::A_PULSE: s_nxt.dat = {16'h0, s_r.pulse_ms};
         disc_ctrl_pkg::A_INTER: s_nxt.dat = {16'h0, s_r.inter_ms};
         disc_ctrl_pkg::A_MAXOP: s_nxt.dat = {16'h0, s_r.maxop_ms};
         disc_ctrl_pkg::A_STATUS: begin
            s_nxt.dat = {23'h0, s_r.maxop_on, s_r.st != disc_ctrl_pkg::CMD_IDLE,
                         s_r.close_p, s_r.open_p, s_r.op_p, s_r.closed_f,
                         s_r.opened_f, s_r.code};
         end
         disc_ctrl_pkg::A_COUNT: s_nxt.dat = {16'h0, s_r.op_count};
         disc_ctrl_pkg::A_IRQ_STAT: s_nxt.dat = {28'h0, s_r.stat};
         disc_ctrl_pkg::A_IRQ_MASK: s_nxt.dat = {28'h0, s_r.mask};
         default: s_nxt.dat = 32'h0;
      endcase

      // Command pulse
      if (cmd_wr && !accept)
         ev[disc_ctrl_pkg::EV_REFUSED] = 1'b1;
      case (s_r.st)
         disc_ctrl_pkg::CMD_IDLE: begin
            if (accept) begin
               s_nxt.pulse_cnt = '0;
               // Off maps to open output, on to close output
               if (req_on) begin
                  s_nxt.st = disc_ctrl_pkg::CMD_CLOSE;
                  s_nxt.close_p = 1'b1;
               end else begin
                  s_nxt.st = disc_ctrl_pkg::CMD_OPEN;
                  s_nxt.open_p = 1'b1;
               end
            end
         end
         disc_ctrl_pkg::CMD_OPEN, disc_ctrl_pkg::CMD_CLOSE: begin
            if (s_r.tick)
               s_nxt.pulse_cnt = s_r.pulse_cnt + 16'h1;
            // Whole ms ticks keep error to one ms
            if (s_r.pulse_cnt >= s_r.pulse_ms) begin
               s_nxt.st = disc_ctrl_pkg::CMD_IDLE;
               s_nxt.open_p = 1'b0;
               s_nxt.close_p = 1'b0;
            end
         end
         default: begin
            s_nxt.st = disc_ctrl_pkg::CMD_IDLE;
            s_nxt.open_p = 1'b0;
            s_nxt.close_p = 1'b0;
         end
      endcase

      // Position filter
      if (raw_code == disc_ctrl_pkg::POS_INTER) begin
         if (s_r.tick && s_r.inter_cnt < s_r.inter_ms)
            s_nxt.inter_cnt = s_r.inter_cnt + 16'h1;
         if (s_r.inter_cnt >= s_r.inter_ms)
            s_nxt.code = disc_ctrl_pkg::POS_INTER;
      end else begin
         s_nxt.inter_cnt = '0;
         s_nxt.code = raw_code;
      end
      if (s_nxt.code != s_r.code) begin
         s_nxt.evt = 1'b1;
         ev[disc_ctrl_pkg::EV_STATE] = 1'b1;
      end
      s_nxt.closed_f = s_nxt.code == disc_ctrl_pkg::POS_ON;
      s_nxt.opened_f = s_nxt.code == disc_ctrl_pkg::POS_OFF;

      // Operation pulse and counter
      if (s_r.op_p && s_r.tick) begin
         s_nxt.op_cnt = s_r.op_cnt - 16'h1;
         if (s_r.op_cnt == 16'h1)
            s_nxt.op_p = 1'b0;
      end
      if (s_nxt.code != s_r.code && (s_nxt.code == disc_ctrl_pkg::POS_ON ||
          s_nxt.code == disc_ctrl_pkg::POS_OFF)) begin
         s_nxt.op_cnt = disc_ctrl_pkg::OP_PULSE_MS;
         s_nxt.op_p = 1'b1;
         ev[disc_ctrl_pkg::EV_OPER] = 1'b1;
         if (!s_r.op_p)
            s_nxt.op_count = s_r.op_count + 16'h1;
      end
      if (cnt_clr)
         s_nxt.op_count = '0;

      // Operating time supervision
      if (s_r.maxop_on) begin
         if (s_r.code != s_r.start_code) begin
            s_nxt.maxop_on = 1'b0;
         end else begin
            if (s_r.tick)
               s_nxt.maxop_cnt = s_r.maxop_cnt + 16'h1;
            if (s_r.maxop_cnt >= s_r.maxop_ms) begin
               s_nxt.maxop_on = 1'b0;
               ev[disc_ctrl_pkg::EV_TIMEOUT] = 1'b1;
            end
         end
      end
      if (accept && s_r.enh) begin
         s_nxt.maxop_on = 1'b1;
         s_nxt.maxop_cnt = '0;
         s_nxt.start_code = s_r.code;
      end

      // New events win over a simultaneous clear
      s_nxt.stat = (s_r.stat & ~w1c) | ev;
      s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
         s_r.pulse_ms <= disc_ctrl_pkg::PULSE_RST_MS;
         s_r.inter_ms <= disc_ctrl_pkg::INTER_RST_MS;
         s_r.maxop_ms <= disc_ctrl_pkg::MAXOP_RST_MS;
         s_r.mask <= disc_ctrl_pkg::MASK_RST;
         s_r.st <= disc_ctrl_pkg::CMD_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign wb_dat_o = s_r.dat;
   assign wb_ack_o = s_r.ack;
   assign open_pulse_out = s_r.open_p;
   assign close_pulse_out = s_r.close_p;
   assign switching_event_pulse = s_r.op_p;
   assign filtered_closed_out = s_r.closed_f;
   assign filtered_opened_out = s_r.opened_f;
   assign position_state_code = s_r.code;
   assign state_event_pulse = s_r.evt;
   assign irq = s_r.irq;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_open_start;
      accept && !req_on |=> open_pulse_out && !close_pulse_out;
   endproperty
   a_open_start: assert property (p_open_start)
      else $error("open pulse did not start");

   property p_close_start;
      accept && req_on |=> close_pulse_out && !open_pulse_out;
   endproperty
   a_close_start: assert property (p_close_start)
      else $error("close pulse did not start");

   property p_op_len;
      $fell(switching_event_pulse) |-> $past(s_r.op_cnt) == 16'h1;
   endproperty
   a_op_len: assert property (p_op_len)
      else $error("switching pulse ended early");

   property p_closed;
      filtered_closed_out |-> position_state_code == disc_ctrl_pkg::POS_ON;
   endproperty
   a_closed: assert property (p_closed)
      else $error("closed indication without on state");

   property p_opened;
      filtered_opened_out |-> position_state_code == disc_ctrl_pkg::POS_OFF;
   endproperty
   a_opened: assert property (p_opened)
      else $error("opened indication without off state");

   property p_count;
      $rose(switching_event_pulse) && !$past(cnt_clr) |->
         s_r.op_count == $past(s_r.op_count) + 16'h1;
   endproperty
   a_count: assert property (p_count)
      else $error("operation counter missed an increment");

   property p_clear;
      cnt_clr |=> s_r.op_count == 16'h0;
   endproperty
   a_clear: assert property (p_clear)
      else $error("operation counter not cleared");

   property p_event;
      position_state_code != $past(position_state_code) |->
         state_event_pulse;
   endproperty
   a_event: assert property (p_event)
      else $error("state change without event");

   property p_one_pulse;
      open_pulse_out |-> !close_pulse_out ##1 !close_pulse_out;
   endproperty
   a_one_pulse: assert property (p_one_pulse)
      else $error("both command pulses active");

   property p_permit;
      $rose(open_pulse_out) |-> $past(s_r.sync2[2]) && !$past(s_r.sync2[6]);
   endproperty
   a_permit: assert property (p_permit)
      else $error("request executed without permission");

endmodule // disc_ctrl

// file: verilog/disc_ctrl_pkg.sv
// Constants shared by the disconnector command and position block.
// Assumes a 200 MHz system clock and a 32-bit classic Wishbone bus.
package disc_ctrl_pkg;

   // ----------------------------------------------------------------
   // Time base
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 200_000_000;
   localparam int TICK_MS = 1;
   localparam int CYC_PER_TICK = CLK_HZ / 1000 * TICK_MS;
   localparam logic [15:0] OP_PULSE_MS = 16'h0096;
   localparam logic [15:0] PULSE_MIN_MS = 16'h0064;
   localparam logic [15:0] PULSE_MAX_MS = 16'hEA60;
   localparam logic [15:0] PULSE_RST_MS = 16'h03E8;
   localparam logic [15:0] INTER_MIN_MS = 16'h0014;
   localparam logic [15:0] INTER_RST_MS = 16'h2710;
   localparam logic [15:0] MAXOP_MIN_MS = 16'h000A;
   localparam logic [15:0] MAXOP_RST_MS = 16'h2710;
   localparam logic [15:0] TIME_MAX_MS = 16'hEA60;

   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_PULSE = 8'h04;
   localparam logic [7:0] A_INTER = 8'h08;
   localparam logic [7:0] A_MAXOP = 8'h0C;
   localparam logic [7:0] A_CMD = 8'h10;
   localparam logic [7:0] A_STATUS = 8'h14;
   localparam logic [7:0] A_COUNT = 8'h18;
   localparam logic [7:0] A_IRQ_STAT = 8'h1C;
   localparam logic [7:0] A_IRQ_MASK = 8'h20;

   // ----------------------------------------------------------------
   // Fields
   // ----------------------------------------------------------------
   localparam int CTRL_ENH_BIT = 0;
   localparam int CMD_ON_BIT = 0;
   localparam int CMD_LOCAL_BIT = 1;
   localparam int IRQ_W = 4;
   localparam int EV_STATE = 0;
   localparam int EV_OPER = 1;
   localparam int EV_REFUSED = 2;
   localparam int EV_TIMEOUT = 3;
   localparam logic [IRQ_W-1:0] MASK_RST = 4'h0;

   // Position codes
   localparam logic [1:0] POS_INTER = 2'h0;
   localparam logic [1:0] POS_OFF = 2'h1;
   localparam logic [1:0] POS_ON = 2'h2;
   localparam logic [1:0] POS_BAD = 2'h3;

   typedef enum logic [1:0] {
      CMD_IDLE = 2'b00,
      CMD_OPEN = 2'b01,
      CMD_CLOSE = 2'b10
   } cmd_state_t;

endpackage

// file: verif/disc_switch_model.sv
// Behavioural disconnector with open and closed position contacts.
// Assumes command pulses from the control block on the same clock.
module disc_switch_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic open_cmd,
   input wire logic close_cmd,
   input wire logic stuck,
   input wire logic force_mid,
   input wire logic force_bad,
   input wire logic [15:0] travel_cyc,
   output logic open_fb,
   output logic closed_fb
);
   timeunit 1ns;
   timeprecision 1ps;
   logic closed_r;
   logic moving_r;
   logic [15:0] cnt_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         closed_r <= 1'b0;
         moving_r <= 1'b0;
         cnt_r <= 16'h0000;
      end else if (moving_r) begin
         cnt_r <= cnt_r + 16'h0001;
         if (cnt_r >= travel_cyc) begin
            moving_r <= 1'b0;
            closed_r <= ~closed_r;
         end
      end else if (!stuck && ((close_cmd && !closed_r) ||
                              (open_cmd && closed_r))) begin
         moving_r <= 1'b1;
         cnt_r <= 16'h0000;
      end
   end

   // Both contacts open while travelling; forcing models a faulty rig
   assign open_fb = force_bad | (~force_mid & ~moving_r & ~closed_r);
   assign closed_fb = force_bad | (~force_mid & ~moving_r & closed_r);
endmodule // disc_switch_model

// file: verif/tb_top.sv
// Self-checking bench for the disconnector control block.
// Assumes a 1 ms tick shortened to 20 clocks and the switch model.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TICK = 20;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_wdat = 32'h0;
   logic [31:0] wb_rdat;
   logic wb_ack;
   logic open_fb, closed_fb;
   logic open_permit = 1'b1;
   logic close_permit = 1'b1;
   logic local_en = 1'b1;
   logic remote_en = 1'b1;
   logic blk = 1'b0;
   logic stuck = 1'b0;
   logic force_mid = 1'b0;
   logic force_bad = 1'b0;
   logic [15:0] travel = 16'h00C8;
   logic open_pulse_out, close_pulse_out, switching_event_pulse;
   logic filtered_closed_out, filtered_opened_out, state_event_pulse, irq;
   logic [1:0] position_state_code;
   int errors = 0;
   int compares = 0;
   int ev_cnt = 0;

   always #2.5 clk = ~clk;
   always @(posedge clk) if (state_event_pulse === 1'b1) ev_cnt++;

   disc_ctrl #(.TICK_CYCLES(TICK)) u_dut (.clk(clk), .rst_n(rst_n),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
      .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
      .open_feedback_in(open_fb), .closed_feedback_in(closed_fb),
      .open_permit_in(open_permit), .close_permit_in(close_permit),
      .local_enable_in(local_en), .remote_enable_in(remote_en),
      .block_in(blk), .open_pulse_out(open_pulse_out),
      .close_pulse_out(close_pulse_out),
      .switching_event_pulse(switching_event_pulse),
      .filtered_closed_out(filtered_closed_out),
      .filtered_opened_out(filtered_opened_out),
      .position_state_code(position_state_code),
      .state_event_pulse(state_event_pulse), .irq(irq));

   disc_switch_model u_model (.clk(clk), .rst_n(rst_n),
      .open_cmd(open_pulse_out), .close_cmd(close_pulse_out),
      .stuck(stuck), .force_mid(force_mid), .force_bad(force_bad),
      .travel_cyc(travel), .open_fb(open_fb), .closed_fb(closed_fb));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_sel <= 4'hF;
      wb_wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 100);
      chk(n < 100, 1'b1);
      q = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask

   function automatic logic sig(int s);
      case (s)
         0: return open_pulse_out;
         1: return close_pulse_out;
         default: return switching_event_pulse;
      endcase
   endfunction

   // Waits for a pulse to start, then returns its length in cycles
   task automatic measure(input int s, output int n);
      int w;
      w = 0;
      n = 0;
      while (sig(s) !== 1'b1 && w < 5000) begin
         @(posedge clk);
         w++;
      end
      while (sig(s) === 1'b1 && n < 100000) begin
         @(posedge clk);
         n++;
      end
   endtask

   task automatic chk_len(input int n, input int ms);
      chk(n >= ms * TICK * 95 / 100 && n <= ms * TICK * 105 / 100, 1'b1);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_regs;
      rdc(disc_ctrl_pkg::A_PULSE, 32'h000003E8);
      rdc(disc_ctrl_pkg::A_INTER, 32'h00002710);
      rdc(disc_ctrl_pkg::A_MAXOP, 32'h00002710);
      rdc(disc_ctrl_pkg::A_IRQ_MASK, 32'h00000000);
      rdc(disc_ctrl_pkg::A_CTRL, 32'h00000000);
      rdc(8'h24, 32'h00000000);
      wr(disc_ctrl_pkg::A_PULSE, 32'h00000032);
      rdc(disc_ctrl_pkg::A_PULSE, 32'h00000064);
      wr(disc_ctrl_pkg::A_PULSE, 32'h0000FFFF);
      rdc(disc_ctrl_pkg::A_PULSE, 32'h0000EA60);
      wr(disc_ctrl_pkg::A_PULSE, 32'h00000064);
   endtask

   task automatic t_settle;
      int n;
      measure(2, n);
      chk(position_state_code, disc_ctrl_pkg::POS_OFF);
      chk(filtered_opened_out, 1'b1);
      chk(filtered_closed_out, 1'b0);
      wr(disc_ctrl_pkg::A_COUNT, 32'h00000000);
      rdc(disc_ctrl_pkg::A_COUNT, 32'h00000000);
   endtask

   task automatic t_close;
      int e0, n1, n2;
      e0 = ev_cnt;
      wr(disc_ctrl_pkg::A_CMD, 32'h00000001);
      fork
         measure(1, n1);
         measure(2, n2);
         begin
            repeat (100) @(posedge clk);
            wr(disc_ctrl_pkg::A_CMD, 32'h00000000);
            repeat (4) @(posedge clk);
            chk(open_pulse_out, 1'b0);
         end
      join
      chk_len(n1, 100);
      chk_len(n2, 150);
      chk(position_state_code, disc_ctrl_pkg::POS_ON);
      chk(filtered_closed_out, 1'b1);
      chk(filtered_opened_out, 1'b0);
      chk(ev_cnt - e0, 1);
      rdc(disc_ctrl_pkg::A_STATUS, 32'h0000000A);
      rdc(disc_ctrl_pkg::A_COUNT, 32'h00000001);
   endtask

   task automatic t_irq;
      rdc(disc_ctrl_pkg::A_IRQ_STAT, 32'h00000007);
      wr(disc_ctrl_pkg::A_IRQ_MASK, 32'h00000004);
      repeat (2) @(posedge clk);
      chk(irq, 1'b1);
      wr(disc_ctrl_pkg::A_IRQ_STAT, 32'h00000004);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      wr(disc_ctrl_pkg::A_IRQ_STAT, 32'h0000000F);
      rdc(disc_ctrl_pkg::A_IRQ_STAT, 32'h00000000);
   endtask

   task automatic t_open;
      int n1, n2;
      for (int i = 0; i < 4; i++) begin
         open_permit <= (i != 0);
         remote_en <= (i != 1);
         blk <= (i == 2);
         local_en <= (i != 3);
         repeat (5) @(posedge clk);
         wr(disc_ctrl_pkg::A_CMD, (i == 3) ? 32'h2 : 32'h0);
         repeat (4) @(posedge clk);
         chk(open_pulse_out, 1'b0);
         rdc(disc_ctrl_pkg::A_IRQ_STAT, 32'h00000004);
         wr(disc_ctrl_pkg::A_IRQ_STAT, 32'h00000004);
      end
      local_en <= 1'b1;
      travel <= 16'h0004;
      repeat (5) @(posedge clk);
      wr(disc_ctrl_pkg::A_CMD, 32'h00000002);
      fork
         measure(0, n1);
         measure(2, n2);
      join
      chk_len(n1, 100);
      chk_len(n2, 150);
      chk(close_pulse_out, 1'b0);
      chk(position_state_code, disc_ctrl_pkg::POS_OFF);
      rdc(disc_ctrl_pkg::A_COUNT, 32'h00000002);
   endtask

   task automatic t_state;
      int e0;
      wr(disc_ctrl_pkg::A_INTER, 32'h00000005);
      rdc(disc_ctrl_pkg::A_INTER, 32'h00000014);
      e0 = ev_cnt;
      force_bad <= 1'b1;
      repeat (10) @(posedge clk);
      chk(position_state_code, disc_ctrl_pkg::POS_BAD);
      chk({filtered_opened_out, filtered_closed_out}, 2'b00);
      force_bad <= 1'b0;
      force_mid <= 1'b1;
      repeat (300) @(posedge clk);
      chk(position_state_code, disc_ctrl_pkg::POS_BAD);
      repeat (200) @(posedge clk);
      chk(position_state_code, disc_ctrl_pkg::POS_INTER);
      chk(ev_cnt - e0, 2);
      force_mid <= 1'b0;
      repeat (3500) @(posedge clk);
   endtask

   task automatic t_timeout;
      wr(disc_ctrl_pkg::A_CTRL, 32'h00000001);
      wr(disc_ctrl_pkg::A_MAXOP, 32'h0000000A);
      wr(disc_ctrl_pkg::A_IRQ_STAT, 32'h0000000F);
      stuck <= 1'b1;
      wr(disc_ctrl_pkg::A_CMD, 32'h00000001);
      repeat (150) @(posedge clk);
      rdc(disc_ctrl_pkg::A_IRQ_STAT, 32'h00000000);
      repeat (150) @(posedge clk);
      rdc(disc_ctrl_pkg::A_IRQ_STAT, 32'h00000008);
      rdc(disc_ctrl_pkg::A_STATUS, 32'h000000C5);
      chk(position_state_code, disc_ctrl_pkg::POS_OFF);
   endtask

   task automatic complete_run;
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_settle();
      t_close();
      t_irq();
      t_open();
      t_state();
      t_timeout();
      complete_run();
   end

   initial begin
      #300us;
      errors++;
      complete_run();
   end
endmodule // tb_top
